// [src/nvm_access_control.sv]
// control logic for self-programming of on-chip nonvolatile memory
// assumes the core drives register select, write and read strobes in its clock domain,
// and that the memory array reports the end of a self-timed cycle on cycle_done_in
//
// the block keeps the access control register, the phantom unlock port and the table
// data latch; the array, its programming timer and the pointer arithmetic live elsewhere
//
// a launch takes its target, erase choice and block base from the value written with the
// start bit and from the pointer in that same cycle; they hold until the cycle ends, so
// software may reload the pointer while the array works
//
// limitation: the error flag powers up clear, because a reset that cuts a cycle short
// cannot be told apart from a cold start inside this block
`timescale 1ns/1ps
module nvm_access_control
	import nvm_access_pkg::*;
#(
	parameter int PTR_WIDTH = PTR_W
)
(
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	// special-function register port
	input  wire logic [1:0]           reg_sel_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	input  wire logic [DATA_W-1:0]    reg_wdata_in,
	output logic      [DATA_W-1:0]    reg_rdata_out,
	// table operations from the core
	input  wire logic [PTR_WIDTH-1:0] table_pointer_in,
	input  wire logic                 table_read_op_in,
	input  wire logic                 table_write_op_in,
	input  wire logic [DATA_W-1:0]    prog_rdata_in,
	// interrupt flag clear by software
	input  wire logic                 irq_flag_clear_in,
	// memory array side
	input  wire logic                 cycle_done_in,
	input  wire logic [DATA_W-1:0]    eeprom_rdata_in,
	output logic                      cycle_start_out,
	output logic                      cycle_erase_out,
	output logic                      cycle_busy_out,
	output logic      [1:0]           cycle_target_out,
	output logic      [PTR_WIDTH-1:0] cycle_addr_out,
	output logic                      hold_wr_out,
	output logic      [2:0]           hold_index_out,
	output logic      [DATA_W-1:0]    hold_wdata_out,
	output logic                      eeprom_rd_out,
	output logic                      write_done_irq_flag_out
);
	// one cycle at a time: a write holds the block until done, a read lasts one clock
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WRITING,
		ST_READING
	} phase_e;

	typedef struct packed {
		phase_e                  phase;
		// control register fields
		logic                    program_space_select;
		logic                    config_space_select;
		logic                    row_erase;
		logic                    write_error_flag;
		logic                    write_permit;
		logic                    write_start;
		logic                    read_start;
		// table latch and registered read data
		logic [DATA_W-1:0]       table_data_latch;
		logic [DATA_W-1:0]       rdata;
		// strobes and qualifiers toward the array
		logic                    cycle_start;
		logic                    cycle_erase;
		logic [1:0]              cycle_target;
		logic [PTR_WIDTH-1:0]    cycle_addr;
		logic                    hold_wr;
		logic [2:0]              hold_index;
		logic [DATA_W-1:0]       hold_wdata;
		logic                    eeprom_rd;
		// write-done interrupt flag
		logic                    irq_flag;
	} ctrl_s;

	ctrl_s state_reg;
	ctrl_s state_next;
	logic  armed;
	logic  unlock_wr;
	logic  other_wr;
	logic  launch;
	// decoded strobes shared by the start logic, the latch and the interrupt flag
	logic  ctrl_wr;
	logic  latch_wr;
	logic  cycle_end;

	// pick the memory a new operation goes to
	function automatic logic [1:0] pick_target(input logic prog_sel, input logic cfg_sel);
		target_e t;
		t = TARGET_EEPROM;
		if (cfg_sel) begin
			t = TARGET_CONFIG;
		end else if (prog_sel) begin
			t = TARGET_PROGRAM;
		end
		return 2'(t);
	endfunction

	// assemble the control register image, unused bit forced low
	function automatic logic [DATA_W-1:0] control_image(input ctrl_s s);
		logic [DATA_W-1:0] v;
		v                = ZERO_BYTE;
		v[BIT_PROG_SEL]  = s.program_space_select;
		v[BIT_CFG_SEL]   = s.config_space_select;
		v[BIT_UNUSED]    = 1'b0;
		v[BIT_ROW_ERASE] = s.row_erase;
		v[BIT_WR_ERROR]  = s.write_error_flag;
		v[BIT_PERMIT]    = s.write_permit;
		v[BIT_WR_START]  = s.write_start;
		v[BIT_RD_START]  = s.read_start;
		return v;
	endfunction

	// decode a write strobe aimed at one register select
	function automatic logic write_hit(input logic wr, input logic [1:0] sel,
		input logic [1:0] want);
		return wr && (sel == want);
	endfunction

	// base address of the block a cycle works on; erase blocks are coarser than write
	// blocks, and the low pointer bits are dropped so the array never sees a misaligned
	// base even when software leaves the pointer in the middle of a block
	function automatic logic [PTR_WIDTH-1:0] block_base(input logic [PTR_WIDTH-1:0] ptr,
		input logic erase);
		logic [PTR_WIDTH-1:0] a;
		a = ptr;
		if (erase) begin
			a[ERASE_LSB-1:0] = '0;
		end else begin
			a[WRITE_LSB-1:0] = '0;
		end
		return a;
	endfunction

	// read data for one register select; the unlock port and the spare select hold nothing
	function automatic logic [DATA_W-1:0] read_mux(input logic [1:0] sel, input ctrl_s s);
		logic [DATA_W-1:0] d;
		d = ZERO_BYTE;
		case (sel)
			SEL_CONTROL: d = control_image(s);
			SEL_LATCH:   d = s.table_data_latch;
			SEL_UNLOCK:  d = ZERO_BYTE;
			default:     d = ZERO_BYTE;
		endcase
		return d;
	endfunction

	assign unlock_wr = write_hit(reg_wr_in, reg_sel_in, SEL_UNLOCK);
	assign other_wr  = reg_wr_in && !unlock_wr;
	assign ctrl_wr   = write_hit(reg_wr_in, reg_sel_in, SEL_CONTROL);
	assign latch_wr  = write_hit(reg_wr_in, reg_sel_in, SEL_LATCH);
	// only a running write can end; a stray done pulse from the array is ignored
	assign cycle_end = (state_reg.phase == ST_WRITING) && cycle_done_in;
	// launch consumes the unlock whether or not it succeeds; none while a cycle runs
	assign launch    = ctrl_wr && reg_wdata_in[BIT_WR_START] && (state_reg.phase == ST_IDLE);

	// the tracker sees writes other than the launch itself as a break in the sequence
	unlock_tracker u_unlock (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.unlock_wr_in (unlock_wr),
		.other_wr_in  (other_wr && !launch),
		.wr_data_in   (reg_wdata_in),
		.consume_in   (launch),
		.armed_out    (armed)
	);

	// next state of the whole block
	always_comb begin
		state_next             = state_reg;
		state_next.cycle_start = 1'b0;
		state_next.hold_wr     = 1'b0;
		state_next.eeprom_rd   = 1'b0;

		// control register write; selects frozen during a cycle to keep the target stable
		if (ctrl_wr && state_reg.phase == ST_IDLE) begin
			state_next.program_space_select = reg_wdata_in[BIT_PROG_SEL];
			state_next.config_space_select  = reg_wdata_in[BIT_CFG_SEL];
			state_next.row_erase            = reg_wdata_in[BIT_ROW_ERASE];
			state_next.write_permit         = reg_wdata_in[BIT_PERMIT];
			state_next.write_error_flag     = reg_wdata_in[BIT_WR_ERROR];
			// a start attempt always flags the error bit; a clean completion or a non-start control write with it low clears it
			if (launch) begin
				state_next.write_error_flag = 1'b1;
				state_next.cycle_target = pick_target(reg_wdata_in[BIT_PROG_SEL],
					reg_wdata_in[BIT_CFG_SEL]);
				// refused launch keeps the flag set as an improper attempt
				if (armed && reg_wdata_in[BIT_PERMIT]) begin
					state_next.write_start = 1'b1;
					state_next.cycle_start = 1'b1;
					state_next.cycle_erase = reg_wdata_in[BIT_ROW_ERASE];
					state_next.phase       = ST_WRITING;
					state_next.cycle_addr  = block_base(table_pointer_in,
						reg_wdata_in[BIT_ROW_ERASE]);
				end
			end else if (reg_wdata_in[BIT_RD_START] && !reg_wdata_in[BIT_PROG_SEL]
				&& !reg_wdata_in[BIT_CFG_SEL]) begin
				state_next.read_start = 1'b1;
				state_next.eeprom_rd  = 1'b1;
				state_next.phase      = ST_READING;
			end
			// written zeros to the start bits are ignored by keeping the old values above
		end

		case (state_reg.phase)
			ST_IDLE: begin
				// nothing runs; control writes are taken above
			end
			ST_WRITING: begin
				if (cycle_end) begin
					state_next.write_start      = 1'b0;
					state_next.write_error_flag = 1'b0;
					state_next.phase            = ST_IDLE;
					state_next.irq_flag         = 1'b1;
					if (state_reg.cycle_erase) begin
						state_next.row_erase = 1'b0;
					end
					// selects are left alone so a failed target stays traceable
				end
			end
			ST_READING: begin
				// one-cycle read: data lands in the latch and the strobe clears
				state_next.read_start       = 1'b0;
				state_next.table_data_latch = eeprom_rdata_in;
				state_next.phase            = ST_IDLE;
			end
			default: begin
				state_next.phase = ST_IDLE;
			end
		endcase

		// software clear loses to a completion in the same cycle
		if (irq_flag_clear_in && !cycle_end) begin
			state_next.irq_flag = 1'b0;
		end

		// table latch: software write, table read fills it, table write drains it
		if (latch_wr) begin
			state_next.table_data_latch = reg_wdata_in;
		end
		if (table_read_op_in) begin
			state_next.table_data_latch = prog_rdata_in;
		end
		if (table_write_op_in) begin
			state_next.hold_wr    = 1'b1;
			state_next.hold_index = table_pointer_in[WRITE_LSB-1:0];
			state_next.hold_wdata = state_reg.table_data_latch;
		end

		// registered read data
		state_next.rdata = ZERO_BYTE;
		if (reg_rd_in) begin
			state_next.rdata = read_mux(reg_sel_in, state_reg);
		end
	end

	// error flag reset value is left set-safe at zero; a reset mid-cycle cannot be seen here
	// the selects and latch also come up clear; the array must abandon a cycle on reset too
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg       <= '0;
			state_reg.phase <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// every output is a register bit, so the array and the core see no decode glitches
	assign reg_rdata_out           = state_reg.rdata;
	assign cycle_start_out         = state_reg.cycle_start;
	assign cycle_erase_out         = state_reg.cycle_erase;
	assign cycle_busy_out          = state_reg.write_start;
	assign cycle_target_out        = state_reg.cycle_target;
	assign cycle_addr_out          = state_reg.cycle_addr;
	assign hold_wr_out             = state_reg.hold_wr;
	assign hold_index_out          = state_reg.hold_index;
	assign hold_wdata_out          = state_reg.hold_wdata;
	assign eeprom_rd_out           = state_reg.eeprom_rd;
	assign write_done_irq_flag_out = state_reg.irq_flag;
endmodule

// [src/nvm_access_pkg.sv]
// constants for the nonvolatile memory access control block
// assumes a core that reaches its special-function registers by a select and strobes
package nvm_access_pkg;
	localparam int          DATA_W         = 8;
	localparam int          PTR_W          = 22;
	// register selects on the special-function port
	localparam logic [1:0]  SEL_CONTROL    = 2'h0;
	localparam logic [1:0]  SEL_UNLOCK     = 2'h1;
	localparam logic [1:0]  SEL_LATCH      = 2'h2;
	// control register field positions
	localparam int          BIT_PROG_SEL   = 7;
	localparam int          BIT_CFG_SEL    = 6;
	localparam int          BIT_UNUSED     = 5;
	localparam int          BIT_ROW_ERASE  = 4;
	localparam int          BIT_WR_ERROR   = 3;
	localparam int          BIT_PERMIT     = 2;
	localparam int          BIT_WR_START   = 1;
	localparam int          BIT_RD_START   = 0;
	// unlock keys
	localparam logic [7:0]  UNLOCK_KEY1    = 8'h55;
	localparam logic [7:0]  UNLOCK_KEY2    = 8'hAA;
	// table pointer block boundaries
	localparam int          ERASE_LSB      = 6;
	localparam int          WRITE_LSB      = 3;
	localparam logic [7:0]  ZERO_BYTE      = 8'h00;
	// memory targets
	typedef enum logic [1:0] {
		TARGET_EEPROM,
		TARGET_PROGRAM,
		TARGET_CONFIG
	} target_e;
endpackage

// [src/unlock_tracker.sv]
// unlock sequence tracker: arms after the two keys written back to back
// assumes writes to the unlock port arrive as single-cycle strobes
`timescale 1ns/1ps
module unlock_tracker
	import nvm_access_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              unlock_wr_in,
	input  wire logic              other_wr_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	input  wire logic              consume_in,
	output logic                   armed_out
);
	typedef struct packed {
		logic key1_seen;
		logic armed;
	} tracker_s;

	tracker_s state_reg;
	tracker_s state_next;

	// any other register write between the keys breaks the sequence
	always_comb begin
		state_next = state_reg;
		if (unlock_wr_in) begin
			state_next.armed     = state_reg.key1_seen && (wr_data_in == UNLOCK_KEY2);
			state_next.key1_seen = (wr_data_in == UNLOCK_KEY1);
		end else if (other_wr_in || consume_in) begin
			state_next.key1_seen = 1'b0;
			if (consume_in) begin
				state_next.armed = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign armed_out = state_reg.armed;
endmodule

// [testbench/nvm_access_control_assertions.sv]
// port checker for the nonvolatile access control block
// assumes the single clock domain and active-high async reset of the block
`timescale 1ns/1ps
module nvm_access_control_checker
	import nvm_access_pkg::*;
#(
	parameter int PTR_WIDTH = PTR_W
)(
	input wire logic                 clk_in,
	input wire logic                 rst_in,
	input wire logic                 reg_wr_in,
	input wire logic                 reg_rd_in,
	input wire logic [1:0]           reg_sel_in,
	input wire logic [DATA_W-1:0]    reg_wdata_in,
	input wire logic [DATA_W-1:0]    reg_rdata_out,
	input wire logic [PTR_WIDTH-1:0] table_pointer_in,
	input wire logic [PTR_WIDTH-1:0] cycle_addr_out,
	input wire logic                 table_write_op_in,
	input wire logic                 irq_flag_clear_in,
	input wire logic                 cycle_done_in,
	input wire logic                 cycle_start_out,
	input wire logic                 cycle_erase_out,
	input wire logic                 cycle_busy_out,
	input wire logic [1:0]           cycle_target_out,
	input wire logic                 hold_wr_out,
	input wire logic                 eeprom_rd_out,
	input wire logic                 write_done_irq_flag_out,
	input wire logic [2:0]           hold_index_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// reads of the unlock port and the spare bit carry nothing
	a_unlock_reads_zero: assert property (
		reg_rd_in && reg_sel_in == SEL_UNLOCK |=> reg_rdata_out == ZERO_BYTE)
		else $error("unlock port read nonzero");
	a_spare_bit_zero: assert property (
		reg_rd_in && reg_sel_in == SEL_CONTROL |=> !reg_rdata_out[BIT_UNUSED])
		else $error("spare control bit set");
	// launch target follows the written selects, config winning
	a_launch_target: assert property (
		cycle_start_out |-> cycle_busy_out && cycle_target_out ==
		($past(reg_wdata_in[BIT_CFG_SEL]) ? 2'(TARGET_CONFIG)
		: ($past(reg_wdata_in[BIT_PROG_SEL]) ? 2'(TARGET_PROGRAM) : 2'(TARGET_EEPROM))))
		else $error("launch target wrong");
	a_block_align: assert property (
		cycle_start_out |-> cycle_addr_out[WRITE_LSB-1:0] == '0
		&& (!cycle_erase_out || cycle_addr_out[ERASE_LSB-1:0] == '0))
		else $error("block address unaligned");
	a_no_permit_no_start: assert property (
		reg_wr_in && reg_sel_in == SEL_CONTROL && !reg_wdata_in[BIT_PERMIT] && !cycle_busy_out
		|=> !cycle_start_out)
		else $error("launch without permit");
	a_busy_ends_done: assert property (
		cycle_busy_out && cycle_done_in |=> !cycle_busy_out && write_done_irq_flag_out)
		else $error("completion not seen");
	a_irq_sticky: assert property (
		write_done_irq_flag_out && !irq_flag_clear_in |=> write_done_irq_flag_out)
		else $error("done flag lost");
	a_read_pulse: assert property (
		eeprom_rd_out |=> !eeprom_rd_out)
		else $error("read longer than one cycle");
	a_read_refused: assert property (
		reg_wr_in && reg_sel_in == SEL_CONTROL && reg_wdata_in[BIT_RD_START]
		&& (reg_wdata_in[BIT_PROG_SEL] || reg_wdata_in[BIT_CFG_SEL]) |=> !eeprom_rd_out)
		else $error("read not refused");
	a_hold_index: assert property (
		table_write_op_in |=> hold_wr_out
		&& hold_index_out == $past(table_pointer_in[WRITE_LSB-1:0]))
		else $error("holding index wrong");
	c_erase: cover property (cycle_start_out && cycle_erase_out);
	c_config: cover property (cycle_start_out && cycle_target_out == 2'(TARGET_CONFIG));
	c_read: cover property (eeprom_rd_out);
	c_refused: cover property (reg_wr_in && reg_sel_in == SEL_CONTROL
		&& reg_wdata_in[BIT_WR_START] && !cycle_busy_out ##1 !cycle_start_out);
endmodule
bind nvm_access_control nvm_access_control_checker #(.PTR_WIDTH(PTR_WIDTH)) chk_i (.*);

// [testbench/nvm_access_control_tb.sv]
// self-checking bench for the nonvolatile access control block
// assumes the array model answers launches after a short fixed delay
`timescale 1ns/1ps
module nvm_access_control_tb;
	import nvm_access_pkg::*;
	logic clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, tr = 0, tw = 0, iclr = 0;
	logic [1:0] reg_sel_in = 0, ctgt;
	logic [7:0] reg_wdata_in = 0, rdata, prog_d, ee_d, hdat;
	logic [21:0] tp = 0, caddr;
	logic cst, cer, cbusy, cdone, hw, erd, irq;
	logic [2:0] hidx;
	int mismatches = 0, cmp_count = 0;
	always #2 clk_in = ~clk_in;
	nvm_access_control uut (.clk_in(clk_in), .rst_in(rst_in), .reg_sel_in(reg_sel_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(rdata), .table_pointer_in(tp), .table_read_op_in(tr),
		.table_write_op_in(tw), .prog_rdata_in(prog_d), .irq_flag_clear_in(iclr),
		.cycle_done_in(cdone), .eeprom_rdata_in(ee_d), .cycle_start_out(cst),
		.cycle_erase_out(cer), .cycle_busy_out(cbusy), .cycle_target_out(ctgt),
		.cycle_addr_out(caddr), .hold_wr_out(hw), .hold_index_out(hidx),
		.hold_wdata_out(hdat), .eeprom_rd_out(erd), .write_done_irq_flag_out(irq));
	nvm_array_model mem (.clk_in(clk_in), .rst_in(rst_in), .start_in(cst), .eeprom_rd_in(erd),
		.table_read_in(tr), .done_out(cdone), .eeprom_rdata_out(ee_d), .prog_rdata_out(prog_d));
	// compare and count; case inequality so unknowns fail
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// each access waits one falling edge first so strobes never toggle twice at once
	task wr(input logic [1:0] s, input logic [7:0] d);
		@(negedge clk_in);
		reg_sel_in = s;
		reg_wdata_in = d;
		reg_wr_in = 1;
		@(negedge clk_in);
		reg_wr_in = 0;
	endtask
	task rd(input logic [1:0] s, input logic [7:0] e);
		@(negedge clk_in);
		reg_sel_in = s;
		reg_rd_in = 1;
		@(negedge clk_in);
		reg_rd_in = 0;
		chk("rdata", e, rdata);
	endtask
	// two keys then the control value, back to back; the strobe stays up across all three
	task seq(input logic [7:0] ctl);
		@(negedge clk_in);
		reg_sel_in = SEL_UNLOCK;
		reg_wdata_in = UNLOCK_KEY1;
		reg_wr_in = 1;
		@(negedge clk_in);
		reg_wdata_in = UNLOCK_KEY2;
		@(negedge clk_in);
		reg_sel_in = SEL_CONTROL;
		reg_wdata_in = ctl;
		@(negedge clk_in);
		reg_wr_in = 0;
	endtask
	task finish_test;
		if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task t_launch(input logic [7:0] ctl, input logic [21:0] p, input logic [1:0] tg);
		int i;
		tp = p;
		seq(ctl);
		chk("start", 1, cst);
		chk("target", tg, ctgt);
		chk("erase", ctl[4], cer);
		chk("addr", ctl[4] ? {p[21:6], 6'h00} : {p[21:3], 3'h0}, caddr);
		wr(SEL_CONTROL, 8'h00);
		rd(SEL_CONTROL, ctl | 8'h08);
		for (i = 0; i < 40 && cbusy; i++) @(negedge clk_in);
		if (cbusy) begin
			mismatches++;
			$display("unexpected busy expected 0 seen 1");
			finish_test;
		end
		chk("irq", 1, irq);
		rd(SEL_CONTROL, ctl & 8'hE5);
		@(negedge clk_in) iclr = 1;
		@(negedge clk_in) iclr = 0;
		chk("irq", 0, irq);
	endtask
	task t_refused;
		wr(SEL_CONTROL, 8'h86);
		chk("busy", 0, cbusy);
		rd(SEL_CONTROL, 8'h8C);
		seq(8'h82);
		chk("start", 0, cst);
		rd(SEL_CONTROL, 8'h88);
	endtask
	task t_reads;
		wr(SEL_CONTROL, 8'h01);
		chk("eeprom_rd", 1, erd);
		rd(SEL_CONTROL, 8'h00);
		rd(SEL_LATCH, mem.EE_VAL);
		wr(SEL_CONTROL, 8'hC1);
		chk("eeprom_rd", 0, erd);
		wr(SEL_CONTROL, 8'h20);
		rd(SEL_CONTROL, 8'h00);
		rd(2'h3, 8'h00);
		@(negedge clk_in) tr = 1;
		@(negedge clk_in) tr = 0;
		rd(SEL_LATCH, mem.PROG_VAL);
		wr(SEL_LATCH, 8'h5A);
		tp = 22'h2ABCDD;
		@(negedge clk_in) tw = 1;
		@(negedge clk_in) tw = 0;
		chk("hold", {1'b1, 3'h5, 8'h5A}, {hw, hidx, hdat});
	endtask
	// reset in the middle of a running write returns the block to its power-up state
	task t_reset;
		seq(8'h86);
		chk("busy", 1, cbusy);
		rst_in = 1;
		repeat (2) @(negedge clk_in);
		rst_in = 0;
		chk("busy", 0, cbusy);
		rd(SEL_CONTROL, 8'h00);
	endtask
	initial begin
		repeat (2) @(negedge clk_in);
		rst_in = 0;
		rd(SEL_CONTROL, 8'h00);
		rd(SEL_UNLOCK, 8'h00);
		t_launch(8'h86, 22'h12345, 2'h1);
		t_launch(8'h96, 22'h2ABCDE, 2'h1);
		t_launch(8'h06, 22'h00017, 2'h0);
		t_launch(8'hC6, 22'h20000, 2'h2);
		t_refused();
		t_reads();
		t_reset();
		finish_test;
	end
endmodule

// [testbench/nvm_array_model.sv]
// memory array stand-in: self-timed cycles and read data lines
// assumes start, read and table-read strobes are single-cycle pulses
`timescale 1ns/1ps
module nvm_array_model #(
	parameter int         DELAY    = 20,
	parameter logic [7:0] EE_VAL   = 8'hC3,
	parameter logic [7:0] PROG_VAL = 8'h3C
)(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       start_in,
	input  wire logic       eeprom_rd_in,
	input  wire logic       table_read_in,
	output logic            done_out,
	output logic [7:0]      eeprom_rdata_out,
	output logic [7:0]      prog_rdata_out
);
	int cnt_reg;
	// done pulses DELAY cycles after a launch
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg  <= 0;
			done_out <= 1'b0;
		end else begin
			done_out <= (cnt_reg == 1);
			if (start_in) cnt_reg <= DELAY;
			else if (cnt_reg != 0) cnt_reg <= cnt_reg - 1;
		end
	end
	// data valid only in its read cycle; inverted otherwise so a late sample shows
	assign eeprom_rdata_out = eeprom_rd_in ? EE_VAL : ~EE_VAL;
	assign prog_rdata_out   = table_read_in ? PROG_VAL : ~PROG_VAL;
endmodule
